// *** hdl/swf_defs.svh ***
`ifndef SWF_DEFS_SVH
`define SWF_DEFS_SVH
// How it works
// - output swings around the set frequency
// - zero amplitude setting disables the swing
// - base select: 0 centre, 1 maximum frequency
// - amplitude equals base times amplitude percent
// - jump equals amplitude times jump percent
// - swung frequency clamped to upper/lower limits
// - one triangle period lasts the cycle time
// - rise lasts cycle times coefficient, fall remainder
// - length equals pulses divided by pulses-per-metre
// - output on when length exceeds target length
// - function 28 input clears accumulated length, only under fixed-length control
// - length pulses counted only on function 27
// - event pulses counted only on function 25
// - final threshold sets flag and stops counting
// - intermediate threshold sets flag, counting continues

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SWF_CLK_PERIOD_NS 40
`define SWF_MS_TICK_NS 1000000
`define SWF_MS_TICK_CYCLES (`SWF_MS_TICK_NS / `SWF_CLK_PERIOD_NS)
`define SWF_MS_PER_CYCLE_UNIT 100
`define SWF_PERMILLE 1000
`define SWF_PPM_SCALE 10

// ----------------------------------------------------------------
// input function codes and inputs
// ----------------------------------------------------------------
`define SWF_FN_COUNT_IN 6'h19
`define SWF_FN_LEN_IN 6'h1B
`define SWF_FN_LEN_CLR 6'h1C
`define SWF_NUM_IN 5
`define SWF_HS_IN_IDX 4

// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define SWF_LEN_MAX 16'hFFFF
`define SWF_RST_COUNT 16'h0000
`define SWF_RST_PULSES 32'h0000_0000
`endif

// *** hdl/swf_pkg.sv ***
package swf_pkg;
  // swing wave configuration, units 0.1 % and 0.1 s
  typedef struct packed {
    logic base_sel;       // 0 centre, 1 maximum
    logic [9:0] amp_pct;  // 0..1000
    logic [9:0] jump_pct; // 0..500
    logic [15:0] cycle;   // 1..30000
    logic [9:0] rise_coef; // 1..1000
  } swf_swing_cfg_s;
  // frequency references, 0.01 Hz units
  typedef struct packed {
    logic [15:0] centre;
    logic [15:0] max_freq;
    logic [15:0] upper;
    logic [15:0] lower;
  } swf_freq_s;
  // position of the triangle wave
  typedef enum logic [1:0] {SWF_IDLE, SWF_RISE, SWF_FALL} swf_phase_e;
endpackage

// *** hdl/swf_top.sv ***
`timescale 1ns/1ns
`include "swf_defs.svh"
module swf_top #(
  parameter int MS_TICK_CYCLES = `SWF_MS_TICK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire swf_pkg::swf_swing_cfg_s swing_cfg_i,
  input wire swf_pkg::swf_freq_s freq_i,
  input wire logic [15:0] target_length_i,
  input wire logic [15:0] pulses_per_metre_i,
  input wire logic [15:0] final_count_threshold_i,
  input wire logic [15:0] intermediate_count_threshold_i,
  input wire logic fixed_length_en_i,
  input wire logic [`SWF_NUM_IN-1:0] input_pins_i,
  input wire logic [`SWF_NUM_IN-1:0][5:0] input_fn_i,
  output logic [15:0] swing_freq_o,
  output logic [15:0] measured_length_o,
  output logic length_reached_o,
  output logic [15:0] event_count_o,
  output logic count_final_o,
  output logic count_mid_o
);
  // ----------------------------------------------------------------
  // input synchronisers and edge detect
  // ----------------------------------------------------------------
  logic [`SWF_NUM_IN-1:0] s1_r, s2_r, s3_r; // three-stage chain per pin
  logic [`SWF_NUM_IN-1:0] lvl_r; // filtered level, moves when s2 and s3 agree
  logic [`SWF_NUM_IN-1:0] lvl_nxt;
  logic [`SWF_NUM_IN-1:0] rise_in;
  // a pulse shorter than two clocks may vanish in the filter; the far
  // side must keep every level for two clocks at least to be counted
  genvar gi;
  generate
    for (gi = 0; gi < `SWF_NUM_IN; gi++) begin : g_in
      // s1 is read only by s2: metastability stays in the first stage
      always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
          lvl_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= input_pins_i[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          lvl_r[gi] <= lvl_nxt[gi];
        end
      end
      assign lvl_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : lvl_r[gi];
      assign rise_in[gi] = lvl_nxt[gi] & ~lvl_r[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // input function routing
  // ----------------------------------------------------------------
  logic cnt_pulse, len_pulse, len_clr_act;
  // several pins with one function are ORed, so pulses that arrive together on
  // two sources of one function count once, not twice
  always_comb begin
    cnt_pulse = 1'b0;
    len_pulse = 1'b0;
    len_clr_act = 1'b0;
    for (int i = 0; i < `SWF_NUM_IN; i++) begin
      // a pin counts only for the function it is assigned
      if (input_fn_i[i] == `SWF_FN_COUNT_IN) cnt_pulse |= rise_in[i];
      if (input_fn_i[i] == `SWF_FN_LEN_IN) len_pulse |= rise_in[i];
      if (input_fn_i[i] == `SWF_FN_LEN_CLR) len_clr_act |= lvl_r[i];
    end
    // outside fixed-length control the clear pin is ignored
    len_clr_act = len_clr_act & fixed_length_en_i;
  end

  // ----------------------------------------------------------------
  // event counter
  // ----------------------------------------------------------------
  // both thresholds compare against the count after the increment, so a
  // threshold of one fires on the first pulse; zero is not a legal
  // setting and would fire on the first pulse as well
  logic [15:0] event_count_r;
  logic [15:0] count_nxt;
  assign count_nxt = event_count_r + 16'h0001;
  // counting halts once the final flag is up; only reset restarts it
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      event_count_r <= `SWF_RST_COUNT;
      count_final_o <= 1'b0;
      count_mid_o <= 1'b0;
    end else if (cnt_pulse && !count_final_o) begin
      event_count_r <= count_nxt;
      if (count_nxt >= final_count_threshold_i) count_final_o <= 1'b1;
      if (count_nxt >= intermediate_count_threshold_i) count_mid_o <= 1'b1;
    end
  end
  assign event_count_o = event_count_r;

  // ----------------------------------------------------------------
  // length accumulator
  // ----------------------------------------------------------------
  logic [31:0] pulses_r;
  logic [35:0] len_calc;
  logic [15:0] ppm_safe;
  // the accumulator is wider than the length so that long runs at high
  // pulse densities do not wrap before the division
  // clear wins over a coincident pulse: the clear is a held level
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) pulses_r <= `SWF_RST_PULSES;
    else if (len_clr_act) pulses_r <= `SWF_RST_PULSES;
    else if (len_pulse && pulses_r != 32'hFFFF_FFFF) pulses_r <= pulses_r + 32'h0000_0001;
  end
  // pulses-per-metre is in tenths, so scale pulses by ten first
  assign ppm_safe = (pulses_per_metre_i == 16'h0000) ? 16'h0001 : pulses_per_metre_i;
  assign len_calc = (36'(pulses_r) * 36'(`SWF_PPM_SCALE)) / 36'(ppm_safe);
  // the compare uses the registered length, so the output flag lags
  // the length by one clock
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      measured_length_o <= 16'h0000;
      length_reached_o <= 1'b0;
    end else begin
      measured_length_o <= (len_calc > 36'(`SWF_LEN_MAX)) ? `SWF_LEN_MAX : len_calc[15:0];
      length_reached_o <= measured_length_o > target_length_i;
    end
  end

  // ----------------------------------------------------------------
  // millisecond time base
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_r;
  logic ms_tick;
  // the swing timing counts whole milliseconds, which keeps the ramp
  // arithmetic narrow at the cost of one millisecond of resolution;
  // a tick lasts one clock and between ticks the wave position holds
  assign ms_tick = (tick_cnt_r == 32'(MS_TICK_CYCLES - 1));
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i || ms_tick) tick_cnt_r <= 32'h0000_0000;
    else tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
  end

  // ----------------------------------------------------------------
  // amplitude, jump and ramp lengths
  // ----------------------------------------------------------------
  logic [15:0] amp_ref, actual_swing_amplitude, jump_f;
  // with the centre as base, a moving set frequency also moves the
  // size of the swing; with the maximum as base the swing stays fixed
  logic [21:0] cycle_ms, rise_ms, fall_ms, rise_div, fall_div;
  assign amp_ref = swing_cfg_i.base_sel ? freq_i.max_freq : freq_i.centre;
  assign actual_swing_amplitude = 16'((32'(amp_ref) * 32'(swing_cfg_i.amp_pct))
      / 32'(`SWF_PERMILLE));
  assign jump_f = 16'((32'(actual_swing_amplitude) * 32'(swing_cfg_i.jump_pct)) / 32'(`SWF_PERMILLE));
  assign cycle_ms = 22'(32'(swing_cfg_i.cycle) * 32'(`SWF_MS_PER_CYCLE_UNIT));
  assign rise_ms = 22'((32'(cycle_ms) * 32'(swing_cfg_i.rise_coef)) / 32'(`SWF_PERMILLE));
  assign fall_ms = cycle_ms - rise_ms;
  // guard the dividers; a zero-length ramp is skipped by the phase logic
  assign rise_div = (rise_ms == 22'h0) ? 22'h1 : rise_ms;
  assign fall_div = (fall_ms == 22'h0) ? 22'h1 : fall_ms;

  // ----------------------------------------------------------------
  // triangle phase state
  // ----------------------------------------------------------------
  swf_pkg::swf_phase_e phase_r;
  logic [21:0] t_r; // ms within the current ramp
  // a config change mid-ramp takes effect at once; the end test uses >=
  // so a shortened ramp ends on the next tick rather than running on
  // until the position counter wraps
  // idle holds the centre until the first tick, then enters mid-rise
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      phase_r <= swf_pkg::SWF_IDLE;
      t_r <= 22'h0;
    end else if (ms_tick) begin
      case (phase_r)
        swf_pkg::SWF_IDLE: begin
          phase_r <= swf_pkg::SWF_RISE;
          t_r <= rise_ms >> 1;
        end
        swf_pkg::SWF_RISE: begin
          if (t_r + 22'h1 >= rise_ms) begin
            phase_r <= (fall_ms == 22'h0) ? swf_pkg::SWF_RISE : swf_pkg::SWF_FALL;
            t_r <= 22'h0;
          end else begin
            t_r <= t_r + 22'h1;
          end
        end
        swf_pkg::SWF_FALL: begin
          if (t_r + 22'h1 >= fall_ms) begin
            phase_r <= (rise_ms == 22'h0) ? swf_pkg::SWF_FALL : swf_pkg::SWF_RISE;
            t_r <= 22'h0;
          end else begin
            t_r <= t_r + 22'h1;
          end
        end
        default: begin
          phase_r <= swf_pkg::SWF_IDLE;
          t_r <= 22'h0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // swing offset and clamped output
  // ----------------------------------------------------------------
  logic signed [18:0] offset, freq_sum, upper_s, lower_s;
  logic [39:0] ramp;
  logic [16:0] span;
  // clamping acts on the sum, so limits narrower than the swing flatten
  // the triangle into a trapezoid instead of shifting it
  // rise runs from -amplitude+jump up to +amplitude; fall from
  // amplitude-jump down to -amplitude,
  // so each turning point carries the jump step
  always_comb begin
    span = 17'(actual_swing_amplitude) + 17'(actual_swing_amplitude) - 17'(jump_f);
    ramp = 40'h0;
    offset = 19'sh0;
    case (phase_r)
      swf_pkg::SWF_RISE: begin
        ramp = (40'(span) * 40'(t_r)) / 40'(rise_div);
        offset = -$signed(19'(actual_swing_amplitude)) + $signed(19'(jump_f))
            + $signed(19'(ramp[16:0]));
      end
      swf_pkg::SWF_FALL: begin
        ramp = (40'(span) * 40'(t_r)) / 40'(fall_div);
        offset = $signed(19'(actual_swing_amplitude)) - $signed(19'(jump_f))
            - $signed(19'(ramp[16:0]));
      end
      default: offset = 19'sh0;
    endcase
  end
  assign freq_sum = $signed(19'(freq_i.centre)) + offset;
  assign upper_s = $signed(19'(freq_i.upper));
  assign lower_s = $signed(19'(freq_i.lower));
  // reset parks the output at zero; the centre appears one clock after
  // release, while the phase is still idle
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) swing_freq_o <= 16'h0000;
    else if (freq_sum > upper_s) swing_freq_o <= freq_i.upper;
    else if (freq_sum < lower_s) swing_freq_o <= freq_i.lower;
    else swing_freq_o <= freq_sum[15:0];
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  a_final_stops_count: assert property (count_final_o |=> $stable(event_count_r))
    else $error("count moved after final threshold");
  a_final_flag_set: assert property ($rose(count_final_o) |-> event_count_r >= $past(final_count_threshold_i))
    else $error("final flag without threshold");
  a_mid_flag_set: assert property ($rose(count_mid_o) |-> $past(cnt_pulse) && event_count_r == $past(count_nxt))
    else $error("intermediate flag without a pulse");
  a_count_fn_only: assert property (!cnt_pulse |=> $stable(event_count_r))
    else $error("count moved without counter pulse");
  a_len_fn_only: assert property (!len_pulse && !len_clr_act |=> $stable(pulses_r))
    else $error("length moved without length pulse");
  a_len_clear_zero: assert property (len_clr_act |=> pulses_r == 32'h0)
    else $error("length not cleared");
  a_len_reached: assert property (##1 length_reached_o == ($past(measured_length_o) > $past(target_length_i)))
    else $error("length output wrong");
  a_clamp_limits: assert property (freq_i.upper >= freq_i.lower ##1 $stable(freq_i)
      |-> swing_freq_o <= freq_i.upper && swing_freq_o >= freq_i.lower)
    else $error("swing frequency outside limits");
  a_zero_amp_centre: assert property (swing_cfg_i.amp_pct == 10'h0 && freq_i.centre <= freq_i.upper
      && freq_i.centre >= freq_i.lower |=> swing_freq_o == $past(freq_i.centre))
    else $error("zero amplitude still swings");
  a_reset_clear: assert property ($fell(sys_rst_i) |-> event_count_r == 16'h0 && !count_final_o
      && !count_mid_o && pulses_r == 32'h0 && phase_r == swf_pkg::SWF_IDLE)
    else $error("reset left state");
  // the flags are sticky: only reset lowers them
  a_final_sticky: assert property (count_final_o |=> count_final_o)
    else $error("final flag dropped");
  // the intermediate flag is sticky as well, also after counting has halted
  a_mid_sticky: assert property (count_mid_o |=> count_mid_o)
    else $error("intermediate flag dropped");
  // with ordered thresholds the intermediate flag is up no later than the final one
  a_mid_with_final: assert property ($rose(count_final_o)
      && $past(intermediate_count_threshold_i) <= $past(final_count_threshold_i) |-> count_mid_o)
    else $error("final flag before intermediate flag");
  // each counter pulse adds exactly one while counting is open
  a_count_step_one: assert property (cnt_pulse && !count_final_o
      |=> event_count_r == $past(event_count_r) + 16'h0001)
    else $error("count did not step by one");
  // each length pulse adds exactly one unless cleared or saturated
  a_len_step_one: assert property (len_pulse && !len_clr_act && pulses_r != 32'hFFFF_FFFF
      |=> pulses_r == $past(pulses_r) + 32'h0000_0001)
    else $error("length pulses did not step by one");
  // outside fixed-length control the clear pin must leave the length alone
  a_clear_needs_en: assert property (!fixed_length_en_i && !len_pulse |=> $stable(pulses_r))
    else $error("length cleared outside fixed-length control");
  // once the wave runs it never falls back to idle without reset
  a_wave_keeps_run: assert property (phase_r != swf_pkg::SWF_IDLE |=> phase_r != swf_pkg::SWF_IDLE)
    else $error("swing wave fell back to idle");

  c_final_hit: cover property ($rose(count_final_o));
  c_mid_hit: cover property ($rose(count_mid_o) && !count_final_o);
  c_len_hit: cover property ($rose(length_reached_o));
  c_fall_phase: cover property (phase_r == swf_pkg::SWF_FALL);
  // a clear that actually removes counted length
  c_len_clear: cover property (len_clr_act && pulses_r != 32'h0000_0000);
endmodule // swf_top

// *** tb/swf_pulse_src.sv ***
`timescale 1ns/1ns
// -------------------------------------------------------------
// far-side pulse source: sensors wired to the drive's input pins
// -------------------------------------------------------------
module swf_pulse_src (
  input wire logic mclk_i,
  input wire logic start_i,
  input wire logic [2:0] pin_sel_i,
  input wire logic [7:0] count_i,
  output logic busy_o,
  output logic [4:0] pins_o
);
  logic [7:0] left_r; // pulses still to send
  logic [2:0] ph_r; // position in one 6-clock pulse slot
  logic [2:0] sel_r; // pin carrying this burst
  initial begin
    left_r = 8'h00;
    ph_r = 3'h0;
    sel_r = 3'h0;
  end
  // a burst is latched only while idle, so a held start is not taken twice
  always @(posedge mclk_i) begin
    if (start_i && left_r == 8'h00) begin
      left_r <= count_i;
      ph_r <= 3'h0;
      sel_r <= pin_sel_i; // burst goes to the selected pin; every pin, bit 4 included, gets the same 6-clock slots
    end else if (left_r != 8'h00) begin
      ph_r <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
      if (ph_r == 3'h5) begin
        left_r <= left_r - 8'h01;
      end
    end
  end
  assign busy_o = (left_r != 8'h00);
  // three clocks high then three low: both above the two-clock filter minimum
  always_comb begin
    pins_o = 5'h00; // idle pins rest low, pulses are active high
    if (left_r != 8'h00 && ph_r < 3'h3) begin
      pins_o[sel_r] = 1'b1;
    end
  end
endmodule // swf_pulse_src

// *** tb/test_swing_freq_length_counter.sv ***
`timescale 1ns/1ns
`include "swf_defs.svh"
module test_swing_freq_length_counter;
  // -------------------------------------------------------------
  // stimulus rows and bench signals
  // -------------------------------------------------------------
  typedef struct packed {
    logic [2:0] pin; logic [5:0] fn; logic [7:0] n; logic en;
    logic [15:0] ev; logic [15:0] len; logic mid; logic fin; logic rch;
  } swf_cnt_row_s;
  typedef struct packed {
    logic base; logic [9:0] amp; logic [15:0] ctr; logic [15:0] mx;
    logic [15:0] up; logic [15:0] lo; logic [15:0] emax; logic [15:0] emin;
  } swf_swg_row_s;
  swf_cnt_row_s cr [9];
  swf_swg_row_s sr [4];
  logic mclk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  swf_pkg::swf_swing_cfg_s cfg;
  swf_pkg::swf_freq_s freq;
  logic [15:0] target = 16'h0003;
  logic [15:0] ppm = 16'h000A; // 1.0 pulse per metre
  logic [15:0] fin_thr = 16'h0004;
  logic [15:0] mid_thr = 16'h0002; // kept below the final threshold
  logic fix_en = 1'b1;
  logic [4:0] pins;
  logic [4:0][5:0] fns = '0;
  logic [15:0] swing_o, len_o, ev_o, mx, mn;
  logic rch_o, fin_o, mid_o, busy, start = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] cnt = 8'h00;
  int fails = 0;
  int samples_checked = 0;
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  // small tick keeps the ms-based swing short enough to watch whole periods
  swf_top #(.MS_TICK_CYCLES(4)) swf_top_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .swing_cfg_i(cfg),
    .freq_i(freq), .target_length_i(target), .pulses_per_metre_i(ppm), .final_count_threshold_i(fin_thr),
    .intermediate_count_threshold_i(mid_thr), .fixed_length_en_i(fix_en), .input_pins_i(pins),
    .input_fn_i(fns), .swing_freq_o(swing_o), .measured_length_o(len_o), .length_reached_o(rch_o),
    .event_count_o(ev_o), .count_final_o(fin_o), .count_mid_o(mid_o));
  swf_pulse_src swf_pulse_src_inst (.mclk_i(mclk_i), .start_i(start), .pin_sel_i(sel), .count_i(cnt),
    .busy_o(busy), .pins_o(pins));
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic give_verdict;
    if (fails == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // burst of pulses, then room for the synchroniser and output pipeline
  task automatic send(input logic [2:0] p, input logic [7:0] n);
    int k;
    sel = p;
    cnt = n;
    start = 1'b1;
    step(1);
    start = 1'b0;
    for (k = 0; k < 3000 && busy; k++) step(1);
    if (busy) begin
      fails++;
      give_verdict();
    end
    step(8);
  endtask
  task automatic do_reset;
    sys_rst_i = 1'b1;
    step(2);
    chk16("event_count", 16'h0000, ev_o);
    chk16("measured_length", 16'h0000, len_o);
    chk1("count_final", 1'b0, fin_o);
    chk1("count_mid", 1'b0, mid_o);
    sys_rst_i = 1'b0;
    step(4);
    chk16("swing_freq", freq.centre, swing_o);
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    cfg = '{1'b0, 10'h000, 10'h000, 16'h0001, 10'h1F4}; // 0.1 s period, 50 % rise
    freq = '{16'h0BB8, 16'h2328, 16'h270F, 16'h0000};
    cr[0] = '{3'h0, `SWF_FN_COUNT_IN, 8'h01, 1'b1, 16'h0001, 16'h0000, 1'b0, 1'b0, 1'b0};
    cr[1] = '{3'h1, `SWF_FN_LEN_IN, 8'h03, 1'b1, 16'h0001, 16'h0003, 1'b0, 1'b0, 1'b0};
    cr[2] = '{3'h4, `SWF_FN_COUNT_IN, 8'h01, 1'b1, 16'h0002, 16'h0003, 1'b1, 1'b0, 1'b0};
    cr[3] = '{3'h2, 6'h03, 8'h02, 1'b1, 16'h0002, 16'h0003, 1'b1, 1'b0, 1'b0};
    cr[4] = '{3'h4, `SWF_FN_LEN_IN, 8'h01, 1'b1, 16'h0002, 16'h0004, 1'b1, 1'b0, 1'b1};
    cr[5] = '{3'h3, `SWF_FN_COUNT_IN, 8'h03, 1'b1, 16'h0004, 16'h0004, 1'b1, 1'b1, 1'b1};
    cr[6] = '{3'h0, `SWF_FN_COUNT_IN, 8'h02, 1'b1, 16'h0004, 16'h0004, 1'b1, 1'b1, 1'b1};
    cr[7] = '{3'h2, `SWF_FN_LEN_CLR, 8'h01, 1'b0, 16'h0004, 16'h0004, 1'b1, 1'b1, 1'b1};
    cr[8] = '{3'h2, `SWF_FN_LEN_CLR, 8'h01, 1'b1, 16'h0004, 16'h0000, 1'b1, 1'b1, 1'b0};
    sr[0] = '{1'b0, 10'h000, 16'h0BB8, 16'h2328, 16'h270F, 16'h0000, 16'h0BB8, 16'h0BB8};
    sr[1] = '{1'b1, 10'h064, 16'h1388, 16'h03E8, 16'h270F, 16'h0000, 16'h13EC, 16'h1324};
    sr[2] = '{1'b0, 10'h064, 16'h07D0, 16'h2328, 16'h270F, 16'h0000, 16'h0898, 16'h0708};
    sr[3] = '{1'b0, 10'h064, 16'h07D0, 16'h2328, 16'h0834, 16'h076C, 16'h0834, 16'h076C};
    do_reset();
    // counting, thresholds and length through the pin-function table
    foreach (cr[i]) begin
      fns = '0;
      fns[cr[i].pin] = cr[i].fn;
      fix_en = cr[i].en;
      send(cr[i].pin, cr[i].n);
      chk16("event_count", cr[i].ev, ev_o);
      chk16("measured_length", cr[i].len, len_o);
      chk1("count_mid", cr[i].mid, mid_o);
      chk1("count_final", cr[i].fin, fin_o);
      chk1("length_reached", cr[i].rch, rch_o);
    end
    // mid-run reset, then 2.5 pulses per metre: five pulses make two metres
    do_reset();
    ppm = 16'h0019;
    fns = '0;
    fns[1] = `SWF_FN_LEN_IN;
    send(3'h1, 8'h05);
    chk16("measured_length", 16'h0002, len_o);
    // swing extremes over two full periods for each setting
    foreach (sr[i]) begin
      cfg.base_sel = sr[i].base;
      cfg.amp_pct = sr[i].amp;
      freq = '{sr[i].ctr, sr[i].mx, sr[i].up, sr[i].lo};
      do_reset();
      mx = 16'h0000;
      mn = 16'hFFFF;
      repeat (900) begin
        step(1);
        if (swing_o > mx) mx = swing_o;
        if (swing_o < mn) mn = swing_o;
      end
      chk16("swing_max", sr[i].emax, mx);
      chk16("swing_min", sr[i].emin, mn);
    end
    give_verdict();
  end
endmodule // test_swing_freq_length_counter
